/* logic/tmrr_consts.svh */
// Constants of the tunnel-mode read/write relay: command codes, limits, sizes.
// Assumes inclusion by bare name from the design file.
`ifndef TMRR_CONSTS_SVH
`define TMRR_CONSTS_SVH
`define TMRR_JIS_READ_CMD    8'h06
`define TMRR_JIS_READ_RSP    8'h07
`define TMRR_JIS_WRITE_CMD   8'h08
`define TMRR_JIS_WRITE_RSP   8'h09
`define TMRR_TB_READ_INS     8'hB0
`define TMRR_TB_WRITE_INS    8'hD6
`define TMRR_TB_CLA          8'h00
`define TMRR_POLL_CMD        8'h28
`define TMRR_RESULT_OK       8'hF8
`define TMRR_RESULT_ERR      8'hE8
`define TMRR_SVC_MIN         8'h01
`define TMRR_SVC_MAX         8'h0B
`define TMRR_SVC_SPLIT       8'h08
`define TMRR_BLK_MAX_LOW     8'h0C
`define TMRR_BLK_MAX_HIGH    8'h0B
`define TMRR_BLK_MIN         8'h01
`define TMRR_ID_BYTES        8
`define TMRR_BLOCK_BYTES     16
`define TMRR_TB_MAX_READ     8'hFB
`define TMRR_TB_MAX_WRITE    8'hF8
`define TMRR_HST_OK          8'h00
`define TMRR_HST_BUSY        8'h01
`define TMRR_HST_ERR         8'h02
`define TMRR_SF_OK           8'h00
`define TMRR_SF_ERR          8'hA1
`define TMRR_SW1_OK          8'h90
`define TMRR_SW2_OK          8'h00
`define TMRR_SW1_ERR         8'h6A
`define TMRR_SW2_ERR         8'h86
`endif

/* logic/tmrr_pkg.sv */
// Types of the tunnel-mode read/write relay.
// Assumes the constants header is on the include path.
package tmrr_pkg;
  typedef enum logic [1:0] {TMRR_JIS_READ, TMRR_JIS_WRITE, TMRR_TB_READ, TMRR_TB_WRITE} tmrr_kind_t;
  typedef enum logic [3:0] {
    TMRR_IDLE, TMRR_RF_HDR, TMRR_RF_DATA, TMRR_CHECK, TMRR_WAIT_POLL, TMRR_POLL_RSP,
    TMRR_WAIT_RESULT, TMRR_READ_DATA, TMRR_RESULT_ACK, TMRR_RF_REPLY
  } tmrr_state_t;
endpackage

/* logic/tmrr_fifo.sv */
// Parameterised valid/ready FIFO used in the write data path.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/100ps
module tmrr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output      logic             in_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic             out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tmrr_fifo

/* logic/tmrr_relay.sv */
// Tunnel-mode relay between a contactless reader and a wired serial host.
// Assumes byte streams from already deframed RF and serial front ends on clk_sys.
// What this block does
// - JIS read reply is 0x07, identifier, two flags, count, sixteen bytes per block.
// - Read reply count echoes the command; count and data dropped on error status.
// - Read block data returned is the data the host sent in its result.
// - Type B read returns data then SW1 SW2; only SW1 SW2 on error.
// - JIS write service count accepted only from 0x01 to 0x0B.
// - Service identifier values ignored, but differing identifiers give an error.
// - Write block count 1..12 for up to 8 services, 1..11 for 9..11.
// - Type B write needs class byte 0x00; write instruction is 0xD6.
// - Write poll answer is status, big-endian address, length, then the data.
// - Device acknowledges the result command with one status byte.
// - Write data up to FIFO_DEPTH bytes is held in the FIFO until the poll answer passes it to the host.
// - After the interrupt, host commands other than poll and result get a busy reply.
// - Other reader commands are ignored until the reader reply finishes.
`timescale 1ns/100ps
`include "tmrr_consts.svh"
module tmrr_relay #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        rf_rx_valid,
  input  wire logic [7:0]  rf_rx_data,
  input  wire logic        rf_rx_last,
  input  wire logic        rf_rx_type_b,
  output      logic        rf_tx_valid,
  output      logic [7:0]  rf_tx_data,
  output      logic        rf_tx_last,
  input  wire logic        rf_tx_ready,
  input  wire logic        host_rx_valid,
  input  wire logic [7:0]  host_rx_data,
  input  wire logic        host_rx_last,
  output      logic        host_rx_ready,
  output      logic        host_tx_valid,
  output      logic [7:0]  host_tx_data,
  output      logic        host_tx_last,
  input  wire logic        host_tx_ready,
  output      logic        host_irq,
  output      tmrr_pkg::tmrr_state_t state_out
);
  import tmrr_pkg::*;
  tmrr_state_t      state;
  tmrr_kind_t       kind;
  logic [7:0]       rx_idx;
  logic [7:0]       tx_idx;
  logic [7:0]       card_identifier [`TMRR_ID_BYTES];
  logic [7:0]       svc_cnt;
  logic [7:0]       blk_cnt;
  logic [7:0]       list_len;
  logic [7:0]       elem_next;
  logic [7:0]       first_svc [2];
  logic             svc_mismatch;
  logic [15:0]      start_addr;
  logic [7:0]       data_len;
  logic [7:0]       rd_buf [256];
  logic [7:0]       rd_cnt;
  logic             bad_cmd;
  logic             host_ok;
  logic             reply_busy;
  logic [7:0]       pos;
  logic [7:0]       svc_end;
  logic [7:0]       list_end;
  logic [7:0]       f_in_data;
  logic             f_in_valid;
  logic             f_in_ready;
  logic [7:0]       f_out_data;
  logic             f_out_valid;
  logic             f_out_ready;
  wire              rf_take   = rf_rx_valid && (state == TMRR_IDLE || state == TMRR_RF_HDR);
  wire              host_take = host_rx_valid && host_rx_ready;
  wire              is_poll   = host_rx_data == `TMRR_POLL_CMD;
  wire              is_result = host_rx_data == `TMRR_RESULT_OK
                                || host_rx_data == `TMRR_RESULT_ERR;
  wire              is_write  = kind == TMRR_JIS_WRITE || kind == TMRR_TB_WRITE;
  wire              is_jis    = kind == TMRR_JIS_READ || kind == TMRR_JIS_WRITE;
  wire              svc_bad   = svc_cnt < `TMRR_SVC_MIN || svc_cnt > `TMRR_SVC_MAX;
  wire [7:0]        blk_max   = (svc_cnt <= `TMRR_SVC_SPLIT) ? `TMRR_BLK_MAX_LOW
                                                           : `TMRR_BLK_MAX_HIGH;
  wire              blk_bad   = blk_cnt < `TMRR_BLK_MIN || blk_cnt > blk_max;
  wire              len_bad   = data_len == 8'h00 || data_len > ((kind == TMRR_TB_WRITE)
                                ? `TMRR_TB_MAX_WRITE : `TMRR_TB_MAX_READ);
  wire              tb_hdr    = kind == TMRR_TB_READ || kind == TMRR_TB_WRITE;
  wire [7:0]        rd_len    = tb_hdr ? data_len : 8'(blk_cnt * `TMRR_BLOCK_BYTES);
  wire [7:0]        reply_sf  = host_ok ? `TMRR_SF_OK : `TMRR_SF_ERR;
  wire [7:0]        jis_len   = (kind == TMRR_JIS_READ && host_ok)
                                ? 8'(8'd12 + rd_len) : 8'd11;
  wire [7:0]        tb_len    = (kind == TMRR_TB_READ && host_ok) ? 8'(rd_len + 8'd2) : 8'd2;
  wire [7:0]        reply_len = is_jis ? jis_len : tb_len;
  wire [7:0]        poll_len  = is_write ? 8'(8'd4 + data_len) : 8'd4;
  assign svc_end  = 8'(8'd10 + {svc_cnt[6:0], 1'b0});
  assign list_end = 8'(svc_end + 8'd1 + list_len);
  assign pos      = rx_idx;
  assign state_out = state;
  assign host_irq  = state == TMRR_WAIT_POLL || state == TMRR_POLL_RSP
                     || state == TMRR_WAIT_RESULT || state == TMRR_READ_DATA;
  assign host_rx_ready = !host_tx_valid;
  assign f_in_valid  = rf_rx_valid && state == TMRR_RF_DATA;
  assign f_in_data   = rf_rx_data;
  assign f_out_ready = state == TMRR_POLL_RSP && tx_idx >= 8'd4 && host_tx_ready;
  assign rf_tx_valid = state == TMRR_RF_REPLY;
  assign rf_tx_last  = rf_tx_valid && tx_idx == 8'(reply_len - 8'd1);
  // Builds each byte of the reader reply.
  always_comb begin
    rf_tx_data = 8'h00;
    if (is_jis) begin
      if (tx_idx == 8'd0) rf_tx_data = is_write ? `TMRR_JIS_WRITE_RSP : `TMRR_JIS_READ_RSP;
      else if (tx_idx < 8'd9) rf_tx_data = card_identifier[3'(tx_idx - 8'd1)];
      else if (tx_idx == 8'd9) rf_tx_data = reply_sf;
      else if (tx_idx == 8'd10) rf_tx_data = reply_sf;
      else if (tx_idx == 8'd11) rf_tx_data = blk_cnt;
      else rf_tx_data = rd_buf[8'(tx_idx - 8'd12)];
    end else if (tx_idx < 8'(reply_len - 8'd2)) begin
      rf_tx_data = rd_buf[tx_idx];
    end else if (tx_idx == 8'(reply_len - 8'd2)) begin
      rf_tx_data = host_ok ? `TMRR_SW1_OK : `TMRR_SW1_ERR;
    end else begin
      rf_tx_data = host_ok ? `TMRR_SW2_OK : `TMRR_SW2_ERR;
    end
  end
  // Host transmit byte for poll answers, busy and result acknowledgements.
  always_comb begin
    host_tx_data = reply_busy ? `TMRR_HST_BUSY : `TMRR_HST_OK;
    host_tx_last = 1'b1;
    host_tx_valid = reply_busy || state == TMRR_RESULT_ACK;
    if (state == TMRR_POLL_RSP && !reply_busy) begin
      host_tx_valid = tx_idx < 8'd4 || f_out_valid;
      host_tx_last  = tx_idx == 8'(poll_len - 8'd1);
      case (tx_idx)
        8'd0:    host_tx_data = bad_cmd ? `TMRR_HST_ERR : `TMRR_HST_OK;
        8'd1:    host_tx_data = start_addr[15:8];
        8'd2:    host_tx_data = start_addr[7:0];
        8'd3:    host_tx_data = data_len;
        default: host_tx_data = f_out_data;
      endcase
    end
  end
  // Parses reader commands and the host exchange.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= TMRR_IDLE;
      kind <= TMRR_JIS_READ;
      rx_idx <= 8'h00;
      tx_idx <= 8'h00;
      svc_cnt <= 8'h00;
      blk_cnt <= 8'h00;
      list_len <= 8'h00;
      elem_next <= 8'h00;
      svc_mismatch <= 1'b0;
      start_addr <= 16'h0000;
      data_len <= 8'h00;
      rd_cnt <= 8'h00;
      bad_cmd <= 1'b0;
      host_ok <= 1'b0;
      reply_busy <= 1'b0;
    end else if (ce) begin
      if (reply_busy && host_tx_ready) reply_busy <= 1'b0;
      // Result data bytes are payload, never stray commands.
      if (host_take && host_rx_last && state != TMRR_READ_DATA
          && !(host_irq && (is_poll || is_result))) begin
        reply_busy <= 1'b1;
      end
      case (state)
        TMRR_IDLE, TMRR_RF_HDR: if (rf_take) begin
          rx_idx <= 8'(rx_idx + 8'd1);
          state <= TMRR_RF_HDR;
          if (rx_idx == 8'd0) begin
            bad_cmd <= 1'b0;
            svc_mismatch <= 1'b0;
            if (rf_rx_type_b) begin
              bad_cmd <= rf_rx_data != `TMRR_TB_CLA;
            end else begin
              kind <= (rf_rx_data == `TMRR_JIS_WRITE_CMD) ? TMRR_JIS_WRITE : TMRR_JIS_READ;
            end
          end
          if (rf_rx_type_b) begin
            if (rx_idx == 8'd1) begin
              kind <= (rf_rx_data == `TMRR_TB_WRITE_INS) ? TMRR_TB_WRITE : TMRR_TB_READ;
            end
            if (rx_idx == 8'd2) start_addr[15:8] <= rf_rx_data;
            if (rx_idx == 8'd3) start_addr[7:0] <= rf_rx_data;
            if (rx_idx == 8'd4) begin
              data_len <= rf_rx_data;
              state <= (kind == TMRR_TB_WRITE) ? TMRR_RF_DATA : TMRR_CHECK;
            end
          end else begin
            if (rx_idx >= 8'd1 && rx_idx < 8'd9) card_identifier[3'(rx_idx - 8'd1)] <= rf_rx_data;
            if (rx_idx == 8'd9) svc_cnt <= rf_rx_data;
            if (rx_idx >= 8'd10 && rx_idx < svc_end) begin
              if (rx_idx < 8'd12) first_svc[rx_idx[0]] <= rf_rx_data;
              else if (rf_rx_data != first_svc[rx_idx[0]]) svc_mismatch <= 1'b1;
            end
            if (rx_idx == svc_end) begin
              blk_cnt <= rf_rx_data;
              list_len <= 8'({rf_rx_data[6:0], 1'b0});
              elem_next <= 8'(svc_end + 8'd1);
            end
            // A clear top bit on an element's first byte marks a three-byte element.
            if (rx_idx > svc_end && rx_idx == elem_next) begin
              elem_next <= 8'(rx_idx + (rf_rx_data[7] ? 8'd2 : 8'd3));
              if (!rf_rx_data[7]) list_len <= 8'(list_len + 8'd1);
            end
            if (rx_idx == 8'(list_end - 8'd1) && rx_idx > svc_end) begin
              data_len <= 8'(blk_cnt * `TMRR_BLOCK_BYTES);
              start_addr <= 16'h0000;
              state <= (kind == TMRR_JIS_WRITE) ? TMRR_RF_DATA : TMRR_CHECK;
            end
          end
        end
        TMRR_RF_DATA: if (rf_rx_valid && f_in_ready && rf_rx_last) state <= TMRR_CHECK;
        TMRR_CHECK: begin
          if (is_jis) bad_cmd <= bad_cmd || svc_bad || blk_bad || svc_mismatch;
          else bad_cmd <= bad_cmd || len_bad;
          state <= TMRR_WAIT_POLL;
        end
        TMRR_WAIT_POLL: if (host_take && is_poll) begin
          tx_idx <= 8'h00;
          state <= TMRR_POLL_RSP;
        end
        TMRR_POLL_RSP: if (host_tx_valid && host_tx_ready && !reply_busy) begin
          tx_idx <= 8'(tx_idx + 8'd1);
          if (host_tx_last) state <= TMRR_WAIT_RESULT;
        end
        TMRR_WAIT_RESULT: if (host_take && is_result) begin
          host_ok <= host_rx_data == `TMRR_RESULT_OK && !bad_cmd;
          rd_cnt <= 8'h00;
          state <= (host_rx_data == `TMRR_RESULT_OK && !is_write && !host_rx_last)
                   ? TMRR_READ_DATA : TMRR_RESULT_ACK;
        end
        TMRR_READ_DATA: if (host_take) begin
          rd_buf[rd_cnt] <= host_rx_data;
          rd_cnt <= 8'(rd_cnt + 8'd1);
          if (host_rx_last) state <= TMRR_RESULT_ACK;
        end
        TMRR_RESULT_ACK: if (host_tx_ready && !reply_busy) begin
          tx_idx <= 8'h00;
          state <= TMRR_RF_REPLY;
        end
        TMRR_RF_REPLY: if (rf_tx_ready) begin
          tx_idx <= 8'(tx_idx + 8'd1);
          if (rf_tx_last) begin
            rx_idx <= 8'h00;
            state <= TMRR_IDLE;
          end
        end
        default: state <= TMRR_IDLE;
      endcase
    end
  end
  tmrr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .in_data   (f_in_data),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );
endmodule // tmrr_relay

/* dv/tmrr_relay_props.sv */
// Checker of the tunnel relay's port behaviour.
// Assumes it is bound to tmrr_relay and sees only its ports.
`timescale 1ns/100ps
module tmrr_relay_props (
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  input wire logic                  rf_tx_valid,
  input wire logic [7:0]            rf_tx_data,
  input wire logic                  rf_tx_last,
  input wire logic                  rf_tx_ready,
  input wire logic                  host_rx_valid,
  input wire logic [7:0]            host_rx_data,
  input wire logic                  host_rx_ready,
  input wire logic                  host_tx_valid,
  input wire logic [7:0]            host_tx_data,
  input wire logic                  host_tx_last,
  input wire logic                  host_tx_ready,
  input wire logic                  host_irq,
  input wire tmrr_pkg::tmrr_state_t state_out
);
  import tmrr_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_taken;
    state_out == TMRR_WAIT_POLL && host_rx_valid && host_rx_ready;
  endsequence
  sequence s_busy;
    host_tx_valid && host_tx_data == 8'h01 && host_tx_last;
  endsequence
  property p_poll;
    s_taken ##0 (host_rx_data == 8'h28) |-> ##[0:4] host_tx_valid;
  endproperty
  a_poll: assert property (p_poll) else $error("No answer to the poll.");
  property p_busy;
    s_taken ##0 (host_rx_data != 8'h28) |-> ##[0:4] s_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("No busy answer.");
  property p_ack;
    state_out == TMRR_RESULT_ACK |-> host_tx_valid && host_tx_data == 8'h00 && host_tx_last;
  endproperty
  a_ack: assert property (p_ack) else $error("Bad result acknowledge.");
  property p_wait;
    host_irq |-> !rf_tx_valid;
  endproperty
  a_wait: assert property (p_wait) else $error("Reply before host result.");
  property p_idle;
    state_out == TMRR_IDLE |-> !rf_tx_valid && !host_irq;
  endproperty
  a_idle: assert property (p_idle) else $error("Activity in idle.");
  property p_rf_hold;
    rf_tx_valid && !rf_tx_ready |=> rf_tx_valid && $stable(rf_tx_data) && $stable(rf_tx_last);
  endproperty
  a_rf_hold: assert property (p_rf_hold) else $error("Reply byte not held.");
  property p_host_hold;
    host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("Host byte not held.");
  property p_end;
    rf_tx_valid && rf_tx_ready && rf_tx_last |=> !rf_tx_valid [*2];
  endproperty
  a_end: assert property (p_end) else $error("Reply runs on.");
endmodule // tmrr_relay_props
bind tmrr_relay tmrr_relay_props u_props (.*);

/* dv/tmrr_partner.sv */
// Reader and host stand-in for the tunnel relay.
// Assumes the bench top tmrr_relay_test owns a hang task.
`timescale 1ns/100ps
module tmrr_partner (
  input  wire logic       clk_sys,
  output      logic       rf_rx_valid,
  output      logic [7:0] rf_rx_data,
  output      logic       rf_rx_last,
  output      logic       rf_rx_type_b,
  input  wire logic       rf_tx_valid,
  input  wire logic [7:0] rf_tx_data,
  input  wire logic       rf_tx_last,
  output      logic       rf_tx_ready,
  output      logic       host_rx_valid,
  output      logic [7:0] host_rx_data,
  output      logic       host_rx_last,
  input  wire logic       host_rx_ready,
  input  wire logic       host_tx_valid,
  input  wire logic [7:0] host_tx_data,
  input  wire logic       host_tx_last,
  output      logic       host_tx_ready
);
  logic slow;
  initial begin
    {rf_rx_valid, rf_rx_last, rf_rx_type_b, rf_tx_ready, slow} = '0;
    {host_rx_valid, host_rx_last, host_tx_ready} = '0;
    rf_rx_data = 8'hA5;
    host_rx_data = 8'h5A;
  end
  // Frames come whole from the bench, one byte a cycle.
  task automatic rf_cmd(input logic [7:0] q[$], input logic tb);
    @(posedge clk_sys);
    foreach (q[i]) begin
      rf_rx_valid <= 1'b1;
      rf_rx_type_b <= tb;
      rf_rx_data <= q[i];
      rf_rx_last <= (i == q.size() - 1);
      @(posedge clk_sys);
    end
    rf_rx_valid <= 1'b0;
    rf_rx_last <= 1'b0;
    rf_rx_data <= ~q[q.size() - 1];
  endtask
  // Poll, result and stray commands; each byte held until taken.
  task automatic host_cmd(input logic [7:0] q[$], output logic [7:0] r[$]);
    int n;
    r = {};
    @(posedge clk_sys);
    foreach (q[i]) begin
      host_rx_valid <= 1'b1;
      host_rx_data <= q[i];
      host_rx_last <= (i == q.size() - 1);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (host_rx_ready !== 1'b1 && n < 200);
      if (n >= 200) tmrr_relay_test.hang();
    end
    host_rx_valid <= 1'b0;
    host_rx_last <= 1'b0;
    host_rx_data <= ~q[q.size() - 1];
    host_tx_ready <= 1'b1;
    for (n = 0; n < 600; n++) begin
      @(posedge clk_sys);
      if (host_tx_valid === 1'b1) begin
        r.push_back(host_tx_data);
        if (host_tx_last === 1'b1) break;
      end
    end
    host_tx_ready <= 1'b0;
    if (n >= 600) tmrr_relay_test.hang();
  endtask
  // Reader takes the reply, stalling every other cycle when slow.
  task automatic rf_reply(output logic [7:0] r[$]);
    int n;
    r = {};
    for (n = 0; n < 600; n++) begin
      @(posedge clk_sys);
      if (rf_tx_valid === 1'b1 && rf_tx_ready === 1'b1) begin
        r.push_back(rf_tx_data);
        if (rf_tx_last === 1'b1) break;
      end
      rf_tx_ready <= slow ? !rf_tx_ready : 1'b1;
    end
    rf_tx_ready <= 1'b0;
    if (n >= 600) tmrr_relay_test.hang();
  endtask
endmodule // tmrr_partner

/* dv/tmrr_relay_test.sv */
// Self-checking bench of the tunnel relay.
// Assumes the relay, its FIFO, the partner and the checker compiled before it.
`timescale 1ns/100ps
module tmrr_relay_test;
  import tmrr_pkg::*;
  logic        clk_sys, nrst, ce, rf_rx_valid, rf_rx_last, rf_rx_type_b, rf_tx_ready;
  logic        rf_tx_valid, rf_tx_last, host_rx_valid, host_rx_last, host_rx_ready;
  logic        host_tx_valid, host_tx_last, host_tx_ready, host_irq;
  logic [7:0]  rf_rx_data, rf_tx_data, host_rx_data, host_tx_data;
  tmrr_state_t state_out;
  int          fails, total_checks;
  logic [7:0]  id[$], c[$], d[$], e[$], pr[$], rr[$];
  tmrr_relay #(.FIFO_DEPTH(256)) dut (.*);
  tmrr_partner ptn (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkq(input string what, input logic [7:0] x[$], input logic [7:0] g[$], int n);
    chk({what, "_len"}, 8'(n), 8'(g.size()));
    foreach (x[i]) if (i < g.size()) chk(what, x[i], g[i]);
  endtask
  task automatic hang();
    fails++;
    $display("CHECK FAILED wait expected done seen timeout");
    test_done();
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input logic tb, input logic busy);
    int n;
    ptn.rf_cmd(c, tb);
    for (n = 0; n < 400 && host_irq !== 1'b1; n++) @(posedge clk_sys);
    if (n >= 400) hang();
    if (busy) begin
      ptn.host_cmd('{8'h55}, rr);
      chkq("busy", '{8'h01}, rr, 1);
      ptn.rf_cmd('{8'h06}, tb);
    end
    ptn.host_cmd('{8'h28}, pr);
    ptn.host_cmd(e, rr);
    chkq("ack", '{8'h00}, rr, 1);
    ptn.rf_reply(rr);
    chk("irq_end", 8'h00, {7'h0, host_irq});
  endtask
  task automatic jis_read(input logic ok);
    d = {};
    for (int i = 0; i < 16; i++) d.push_back(8'(8'hC0 + i));
    c = {8'h06, id, 8'h01, 8'h09, 8'h00, 8'h01, 8'h80, 8'h00};
    e = {8'hE8};
    if (ok) e = {8'hF8, d};
    xfer(1'b0, ok);
    chk("rd_poll", 8'h00, pr[0]);
    if (ok) chkq("jrd", {8'h07, id, 8'h00, 8'h00, 8'h01, d}, rr, 28);
    else chkq("jrd_err", {8'h07, id, 8'hA1, 8'hA1}, rr, 11);
  endtask
  task automatic tb_read(input logic ok);
    c = {8'h00, 8'hB0, 8'h12, 8'h34, 8'h03};
    e = {8'hE8};
    if (ok) e = {8'hF8, 8'h3A, 8'h3B, 8'h3C};
    ptn.slow = ok;
    xfer(1'b1, 1'b0);
    ptn.slow = 1'b0;
    chkq("tpoll", {8'h00, 8'h12, 8'h34, 8'h03}, pr, 4);
    if (ok) chkq("trd", {8'h3A, 8'h3B, 8'h3C, 8'h90, 8'h00}, rr, 5);
    else chkq("trd_err", {8'h6A, 8'h86}, rr, 2);
  endtask
  task automatic tb_write(input logic [7:0] cla);
    c = {cla, 8'hD6, 8'h56, 8'h78, 8'h04, 8'hE1, 8'hE2, 8'hE3, 8'hE4};
    e = {8'hF8};
    xfer(1'b1, 1'b0);
    if (cla == 8'h00) chkq("twpoll", {8'h00, c[2:$]}, pr, 8);
    chk("twst", (cla == 8'h00) ? 8'h00 : 8'h02, pr[0]);
    if (cla == 8'h00) chkq("twr", {8'h90, 8'h00}, rr, 2);
    else chkq("twr_err", {8'h6A, 8'h86}, rr, 2);
  endtask
  task automatic jis_write(input logic [7:0] k, input logic same, input logic [7:0] m, logic ok);
    c = {8'h08, id, k};
    d = {};
    for (int i = 0; i < k; i++) c = {c, 8'h09, (!same && i == 1) ? 8'h01 : 8'h00};
    c.push_back(m);
    for (int i = 0; i < m; i++) c = {c, 8'h80, 8'(i)};
    for (int i = 0; i < 16 * m; i++) d.push_back(8'(i * 7 + 3));
    c = {c, d};
    e = {8'hF8};
    xfer(1'b0, 1'b0);
    chk("jwst", ok ? 8'h00 : 8'h02, pr[0]);
    if (ok) chk("jwn", 8'(16 * m), pr[3]);
    if (ok) chkq("jwdata", d, pr[4:$], 16 * m);
    chkq("jwr", {8'h09, id, ok ? 8'h00 : 8'hA1, ok ? 8'h00 : 8'hA1}, rr, 11);
  endtask
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    fails = 0;
    total_checks = 0;
    for (int i = 0; i < 8; i++) id.push_back(8'(8'h21 + i));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    jis_read(1'b1);
    jis_read(1'b0);
    tb_read(1'b1);
    tb_read(1'b0);
    tb_write(8'h00);
    tb_write(8'h01);
    jis_write(8'h01, 1'b1, 8'h01, 1'b1);
    jis_write(8'h0B, 1'b1, 8'h0B, 1'b1);
    jis_write(8'h08, 1'b1, 8'h0C, 1'b1);
    jis_write(8'h0C, 1'b1, 8'h01, 1'b0);
    jis_write(8'h00, 1'b1, 8'h01, 1'b0);
    jis_write(8'h02, 1'b0, 8'h01, 1'b0);
    jis_write(8'h09, 1'b1, 8'h0C, 1'b0);
    test_done();
  end
endmodule // tmrr_relay_test
